// File: sac_pkg.sv
/*
 constants for the successive-approximation converter control block.
 assumes a single 125 MHz clock domain and a plain register port.
*/
package sac_pkg;
  // register byte addresses on the plain port
  localparam logic [15:0] ADDR_MODE = 16'hFF80;
  localparam logic [15:0] ADDR_RESULT = 16'hFF81;
  localparam logic [15:0] ADDR_PIN_SEL = 16'hFF84;
  localparam logic [15:0] ADDR_EDGE_MODE = 16'hFF8C;
  localparam logic [15:0] ADDR_OSC_DIV = 16'hFF8D;
  // reset values
  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam logic [7:0] PIN_SEL_RESET = 8'h00;
  localparam logic [7:0] EDGE_MODE_RESET = 8'h00;
  localparam logic OSC_DIV_RESET = 1'b0;
  // mode register fields
  localparam int MODE_RUN_BIT = 7;
  localparam int MODE_HW_TRIG_BIT = 6;
  localparam int MODE_TIME_HI_BIT = 5;
  localparam int MODE_TIME_LO_BIT = 4;
  localparam int MODE_CH_MSB = 3;
  localparam int MODE_CH_LSB = 1;
  localparam int MODE_SPEED_BIT = 0;
  // trigger edge field in the edge mode register
  localparam int EDGE_MSB = 1;
  localparam int EDGE_LSB = 0;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  // conversion times in main clock periods, divide bit set
  localparam int CONV_T_001 = 80;
  localparam int CONV_T_011 = 40;
  localparam int CONV_T_100 = 50;
  localparam int CONV_T_101 = 100;
  // one decision per bit
  localparam int RES_BITS = 8;
  localparam int CNT_W = 9;
  typedef enum {SAC_IDLE, SAC_WAIT, SAC_CONV} sac_state_t;
endpackage

// File: sac_sync.sv
/*
 three-stage pin synchroniser; a change is taken once stages two and three agree.
 assumes the pin is asynchronous to ref_clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module sac_sync (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // pin and result
  input wire logic pin_i,
  output logic level_o
);
  logic [2:0] stage;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage <= 3'h0;
    end else begin
      stage <= {stage[1:0], pin_i};
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      level_o <= 1'b0;
    end else if (stage[1] == stage[2]) begin
      level_o <= stage[2];
    end
  end
endmodule
`default_nettype wire

// File: sac_timebase.sv
/*
 bit-period divider: pulses once per conversion step for the selected time code.
 assumes code is legal; prohibited codes fall back to the longest step.
*/
`timescale 1ns/100ps
`default_nettype none
module sac_timebase (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // control
  input wire logic clear_i,
  input wire logic [2:0] code_i,
  input wire logic osc_div_i,
  // step pulse
  output logic step_o
);
  logic [sac_pkg::CNT_W-1:0] count;
  logic [sac_pkg::CNT_W-1:0] period;
  logic [sac_pkg::CNT_W-1:0] base;

  always_comb begin
    case (code_i)
      3'h1: base = sac_pkg::CNT_W'(sac_pkg::CONV_T_001 / sac_pkg::RES_BITS);
      3'h3: base = sac_pkg::CNT_W'(sac_pkg::CONV_T_011 / sac_pkg::RES_BITS);
      3'h4: base = sac_pkg::CNT_W'((sac_pkg::CONV_T_100 + sac_pkg::RES_BITS - 1) / sac_pkg::RES_BITS);
      default: base = sac_pkg::CNT_W'(sac_pkg::CONV_T_101 / sac_pkg::RES_BITS);
    endcase
    // divide bit clear doubles every step
    period = osc_div_i ? base : {base[sac_pkg::CNT_W-2:0], 1'b0};
  end

  assign step_o = (count == period - 1'b1);

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count <= '0;
    end else if (clear_i || step_o) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: sac_top.sv
/*
 control for an eight-channel 8-bit successive-approximation converter:
 registers, trigger handling, bit sequencing and result latch.
 assumes the analog comparator answers on compare_i for the trial on trial_code_o.
*/
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// R1: eight analog channels are converted bit by bit into an 8-bit result register.
// R2: in hardware-start mode a valid trigger edge begins a conversion.
// R3: in hardware-start mode the converter stops after one conversion until the next edge.
// R4: in software-start mode conversions repeat back to back on the chosen channel.
// R5: every finished conversion raises the done request in either start mode.
// R6: bits are decided from the top down and the whole word is copied to the result after the last bit.
// R7: the result is read as one byte and holds no defined value after reset.
// R8: pins not chosen as analog inputs stay ordinary port pins.
// R9: the mode register resets to 01H and takes byte or single-bit writes.
// R10: mode bits 3 to 1 choose input n for binary n.
// R11: the time code with the divide bit sets the conversion length; other codes are not to be used.
// R12: with trigger select and run both set the converter waits for the trigger.
// R13: any mode write during a conversion aborts it and restarts if run stays set.
// R14: clearing run stops at once and setting it enables conversion.
// R15: the done request is a one-cycle pulse in the cycle the result updates.
// R16: with run clear the sequencer idles and the result is untouched.
module sac_top (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] wmask_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // analog front end
  input wire logic trigger_i,
  input wire logic compare_i,
  output logic [2:0] channel_o,
  output logic [7:0] trial_code_o,
  output logic sample_o,
  output logic [7:0] analog_en_o,
  // port pins
  input wire logic [7:0] port_pin_i,
  input wire logic [7:0] port_out_i,
  input wire logic [7:0] port_dir_out_i,
  output logic [7:0] port_pin_o,
  output logic [7:0] port_pin_oe_n_o,
  output logic [7:0] port_in_o,
  // event
  output logic conversion_done_irq_o
);
  logic [7:0] converter_mode_reg;
  logic [7:0] conversion_result_reg;
  logic [7:0] approximation_reg;
  logic [3:0] analog_pin_select_reg;
  logic [7:0] trigger_edge_mode_reg;
  logic oscillator_divide_bit;
  logic [3:0] bit_idx;
  logic trig_level;
  logic trig_prev;
  logic trig_edge;
  logic step;
  logic mode_wr;
  logic run;
  logic hw_start;
  logic last_step;
  sac_pkg::sac_state_t state;
  sac_pkg::sac_state_t next_state;

  assign mode_wr = wr_i && (addr_i == sac_pkg::ADDR_MODE);
  assign run = converter_mode_reg[sac_pkg::MODE_RUN_BIT];
  assign hw_start = converter_mode_reg[sac_pkg::MODE_HW_TRIG_BIT];

  // mode register, masked write allows single-bit updates
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      converter_mode_reg <= sac_pkg::MODE_RESET; // R9
    end else if (mode_wr) begin
      converter_mode_reg <= (converter_mode_reg & ~wmask_i) | (wdata_i & wmask_i); // R9
    end
  end

  // pin select, edge mode and divide bit take whole bytes
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      analog_pin_select_reg <= sac_pkg::PIN_SEL_RESET[3:0];
      trigger_edge_mode_reg <= sac_pkg::EDGE_MODE_RESET;
      oscillator_divide_bit <= sac_pkg::OSC_DIV_RESET;
    end else if (wr_i) begin
      if (addr_i == sac_pkg::ADDR_PIN_SEL) begin
        analog_pin_select_reg <= wdata_i[3:0];
      end
      if (addr_i == sac_pkg::ADDR_EDGE_MODE) begin
        trigger_edge_mode_reg <= wdata_i;
      end
      if (addr_i == sac_pkg::ADDR_OSC_DIV) begin
        oscillator_divide_bit <= wdata_i[0];
      end
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        sac_pkg::ADDR_MODE: rdata_o <= converter_mode_reg;
        sac_pkg::ADDR_RESULT: rdata_o <= conversion_result_reg; // R7
        sac_pkg::ADDR_PIN_SEL: rdata_o <= {4'h0, analog_pin_select_reg};
        sac_pkg::ADDR_EDGE_MODE: rdata_o <= trigger_edge_mode_reg;
        sac_pkg::ADDR_OSC_DIV: rdata_o <= {7'h00, oscillator_divide_bit};
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  sac_sync u_trig_sync (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .pin_i(trigger_i),
    .level_o(trig_level)
  );

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= trig_level;
    end
  end

  // edge field: falling, rising, or both
  always_comb begin
    case (trigger_edge_mode_reg[sac_pkg::EDGE_MSB:sac_pkg::EDGE_LSB])
      sac_pkg::EDGE_FALL: trig_edge = trig_prev && !trig_level;
      sac_pkg::EDGE_RISE: trig_edge = !trig_prev && trig_level;
      default: trig_edge = trig_prev != trig_level;
    endcase
  end

  sac_timebase u_timebase (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .clear_i(state != sac_pkg::SAC_CONV || mode_wr),
    .code_i({converter_mode_reg[sac_pkg::MODE_TIME_HI_BIT], converter_mode_reg[sac_pkg::MODE_TIME_LO_BIT],
             converter_mode_reg[sac_pkg::MODE_SPEED_BIT]}), // R11
    .osc_div_i(oscillator_divide_bit), // R11
    .step_o(step)
  );

  assign last_step = (state == sac_pkg::SAC_CONV) && step && (bit_idx == 4'h0) && !mode_wr;

  always_comb begin
    next_state = state;
    case (state)
      sac_pkg::SAC_IDLE: begin
        if (run) begin
          next_state = hw_start ? sac_pkg::SAC_WAIT : sac_pkg::SAC_CONV; // R12 R14
        end
      end
      sac_pkg::SAC_WAIT: begin
        if (trig_edge) begin
          next_state = sac_pkg::SAC_CONV; // R2
        end else if (!hw_start) begin
          // switched to software start while waiting: do not hang on the trigger
          next_state = sac_pkg::SAC_CONV; // R4
        end
      end
      sac_pkg::SAC_CONV: begin
        if (last_step && hw_start) begin
          next_state = sac_pkg::SAC_WAIT; // R3
        end
      end
      default: next_state = sac_pkg::SAC_IDLE;
    endcase
    if (!run) begin
      next_state = sac_pkg::SAC_IDLE; // R14 R16
    end else if (mode_wr && state == sac_pkg::SAC_CONV) begin
      next_state = sac_pkg::SAC_IDLE; // R13
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= sac_pkg::SAC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // approximation from the top bit down; software mode wraps straight on
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      approximation_reg <= 8'h00;
      bit_idx <= 4'h7;
    end else if (state != sac_pkg::SAC_CONV || mode_wr) begin
      approximation_reg <= 8'h00;
      bit_idx <= 4'h7;
    end else if (step && bit_idx == 4'h0) begin
      // word goes to the result now; the next conversion must not see stale low bits
      approximation_reg <= 8'h00; // R4
      bit_idx <= 4'h7; // R4
    end else if (step) begin
      approximation_reg[bit_idx[2:0]] <= compare_i; // R6 R1
      bit_idx <= bit_idx - 4'h1; // R6
    end
  end

  assign trial_code_o = approximation_reg | (8'h01 << bit_idx[2:0]);
  assign sample_o = (state == sac_pkg::SAC_CONV) && (bit_idx == 4'h7);
  assign channel_o = converter_mode_reg[sac_pkg::MODE_CH_MSB:sac_pkg::MODE_CH_LSB]; // R10

  // result has no reset value
  always_ff @(posedge ref_clk_i) begin
    if (last_step) begin
      conversion_result_reg <= {approximation_reg[7:1], compare_i}; // R6 R7
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      conversion_done_irq_o <= 1'b0;
    end else begin
      conversion_done_irq_o <= last_step; // R5 R15
    end
  end

  // analog or port use per pin
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      logic is_analog;
      assign is_analog = (analog_pin_select_reg > 4'(g)); // R8
      assign analog_en_o[g] = is_analog;
      assign port_pin_o[g] = port_out_i[g];
      assign port_pin_oe_n_o[g] = !(port_dir_out_i[g] && !is_analog); // R8
      assign port_in_o[g] = is_analog ? 1'b0 : port_pin_i[g];
    end
  endgenerate
endmodule
`default_nettype wire

// File: sac_top_properties.sv
/*
 port-level checker for the converter control block.
 assumes the single ref_clk_i domain and bind onto sac_top.
*/
`timescale 1ns/100ps
`default_nettype none
module sac_top_properties (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] wmask_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // converter and port side
  input wire logic [2:0] channel_o,
  input wire logic [7:0] trial_code_o,
  input wire logic sample_o,
  input wire logic [7:0] analog_en_o,
  input wire logic [7:0] port_pin_i,
  input wire logic [7:0] port_out_i,
  input wire logic [7:0] port_dir_out_i,
  input wire logic [7:0] port_pin_o,
  input wire logic [7:0] port_pin_oe_n_o,
  input wire logic [7:0] port_in_o,
  input wire logic conversion_done_irq_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_mode_wr;
    wr_i && addr_i == sac_pkg::ADDR_MODE && wmask_i == 8'hFF;
  endsequence
  sequence s_mode_rd;
    rd_i && addr_i == sac_pkg::ADDR_MODE;
  endsequence
  chk_mode_readback: assert property (s_mode_wr ##2 s_mode_rd |=> rdata_o == $past(wdata_i, 3))
    else $error("mode read differs from written byte");
  chk_channel_follow: assert property (s_mode_wr |=> channel_o == $past(wdata_i[3:1]))
    else $error("channel select does not follow mode bits");
  chk_done_pulse: assert property (conversion_done_irq_o |=> !conversion_done_irq_o)
    else $error("done request longer than one cycle");
  chk_stop_quiet: assert property (s_mode_wr ##0 !wdata_i[7] |=> ##1 !conversion_done_irq_o [*8])
    else $error("done request after run cleared");
  chk_first_trial: assert property ($rose(sample_o) |-> trial_code_o == 8'h80)
    else $error("first trial is not the top bit");
  chk_port_out: assert property (port_pin_o == port_out_i)
    else $error("port output not passed through");
  chk_port_enable: assert property (port_pin_oe_n_o == ~(port_dir_out_i & ~analog_en_o))
    else $error("port drive enable wrong");
  chk_port_in: assert property (port_in_o == (port_pin_i & ~analog_en_o))
    else $error("port input value wrong");
endmodule
bind sac_top sac_top_properties chk (.ref_clk_i, .rstn_i, .addr_i, .wdata_i, .wmask_i, .wr_i, .rd_i,
  .rdata_o, .channel_o, .trial_code_o, .sample_o, .analog_en_o, .port_pin_i, .port_out_i,
  .port_dir_out_i, .port_pin_o, .port_pin_oe_n_o, .port_in_o, .conversion_done_irq_o);
`default_nettype wire

// File: sac_analog.sv
/*
 far-side model: eight fixed analog levels with an ideal comparator, and the trigger pin.
 assumes the trial word is settled in the cycle it is judged.
*/
`timescale 1ns/100ps
`default_nettype none
module sac_analog #(
  parameter logic [63:0] LEVELS = 64'h0
) (
  // converter side
  input wire logic [2:0] channel_i,
  input wire logic [7:0] trial_code_i,
  output logic compare_o,
  // trigger pin
  input wire logic fire_i,
  output logic trigger_o
);
  // level of input n sits in byte n
  assign compare_o = LEVELS[channel_i*8 +: 8] >= trial_code_i;
  assign trigger_o = fire_i;
endmodule
`default_nettype wire

// File: sar_adc_control_bench.sv
/*
 testbench for sac_top: register tasks, start modes, timing codes, abort and stop.
 assumes sac_pkg, sac_analog and the bound checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module sar_adc_control_bench;
  localparam logic [63:0] LEVELS = 64'hFF_C3_96_5A_2D_81_00_7E;
  localparam int CEIL = 20000;
  logic ref_clk_i, rstn_i, wr_i, rd_i, fire, trigger_i, compare_i, irq, sample;
  logic [15:0] addr_i;
  logic [7:0] wdata_i, wmask_i, rdata_o, trial, aen, p_o, p_oe, p_in, pin, pout, pdir;
  logic [2:0] ch;
  logic [7:0] modes [5] = '{8'h87, 8'h97, 8'hA6, 8'hA7, 8'h87};
  int steps [5] = '{10, 5, 7, 12, 20};
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  sac_top uut (.ref_clk_i, .rstn_i, .addr_i, .wdata_i, .wmask_i, .wr_i, .rd_i, .rdata_o, .trigger_i,
    .compare_i, .channel_o(ch), .trial_code_o(trial), .sample_o(sample), .analog_en_o(aen),
    .port_pin_i(pin), .port_out_i(pout), .port_dir_out_i(pdir), .port_pin_o(p_o),
    .port_pin_oe_n_o(p_oe), .port_in_o(p_in), .conversion_done_irq_o(irq));
  sac_analog #(.LEVELS(LEVELS)) far (.channel_i(ch), .trial_code_i(trial), .compare_o(compare_i),
    .fire_i(fire), .trigger_o(trigger_i));
  task automatic final_report;
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
    addr_i <= a;
    wdata_i <= d;
    wmask_i <= m;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK("rdata", e, rdata_o)
    @(posedge ref_clk_i);
  endtask
  // counts edges until the done request is seen, or the limit
  task automatic wait_irq(input int lim, output int k);
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (irq !== 1'b1 && k < lim);
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == CEIL) begin
      miscompares++;
      final_report;
    end
  end
  initial begin
    rstn_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 16'h0000;
    wdata_i = 8'h00;
    wmask_i = 8'h00;
    fire = 1'b0;
    pin = 8'hA5;
    pout = 8'h3C;
    pdir = 8'hF0;
    repeat (4) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    rd(sac_pkg::ADDR_MODE, sac_pkg::MODE_RESET);
    rd(16'hFF90, 8'h00);
    wr(sac_pkg::ADDR_MODE, 8'h0E, 8'hFF);
    rd(sac_pkg::ADDR_MODE, 8'h0E);
    wr(sac_pkg::ADDR_MODE, 8'h00, 8'h02);
    rd(sac_pkg::ADDR_MODE, 8'h0C);
    wr(sac_pkg::ADDR_PIN_SEL, 8'h04, 8'hFF);
    wr(sac_pkg::ADDR_PIN_SEL, 8'h08, 8'hFF);
    rd(sac_pkg::ADDR_PIN_SEL, 8'h08);
    wr(sac_pkg::ADDR_OSC_DIV, 8'h01, 8'hFF);
    for (int c = 0; c < 8; c++) begin
      wr(sac_pkg::ADDR_MODE, 8'(8'h81 | (c << 1)), 8'hFF);
      wait_irq(400, n);
      `CHK("done", 1'b1, irq)
      rd(sac_pkg::ADDR_RESULT, LEVELS[c*8 +: 8]);
      wait_irq(400, n);
      `CHK("repeat", 1'b1, irq)
    end
    for (int i = 0; i < 5; i++) begin
      if (i == 4)
        wr(sac_pkg::ADDR_OSC_DIV, 8'h00, 8'hFF);
      wr(sac_pkg::ADDR_MODE, modes[i], 8'hFF);
      wait_irq(400, n);
      wait_irq(400, n);
      `CHK("gap_low", 1'b1, n >= 8 * steps[i])
      `CHK("gap_high", 1'b1, n <= 8 * steps[i] + 3)
    end
    repeat (60) @(posedge ref_clk_i);
    wr(sac_pkg::ADDR_MODE, 8'h87, 8'hFF);
    wait_irq(400, n);
    `CHK("restart", 1'b1, n >= 158)
    wr(sac_pkg::ADDR_MODE, 8'h8F, 8'hFF);
    repeat (50) @(posedge ref_clk_i);
    wr(sac_pkg::ADDR_MODE, 8'h0F, 8'hFF);
    wait_irq(400, n);
    `CHK("stopped", 1'b0, irq)
    rd(sac_pkg::ADDR_RESULT, 8'h2D);
    wr(sac_pkg::ADDR_EDGE_MODE, 8'h01, 8'hFF);
    wr(sac_pkg::ADDR_OSC_DIV, 8'h01, 8'hFF);
    wr(sac_pkg::ADDR_MODE, 8'hCD, 8'hFF);
    wait_irq(300, n);
    `CHK("standby", 1'b0, irq)
    fire <= 1'b1;
    wait_irq(300, n);
    `CHK("hw_done", 1'b1, irq)
    rd(sac_pkg::ADDR_RESULT, 8'hC3);
    wait_irq(300, n);
    `CHK("hw_once", 1'b0, irq)
    // falling edge, then either edge, each start one conversion
    wr(sac_pkg::ADDR_EDGE_MODE, 8'h00, 8'hFF);
    fire <= 1'b0;
    wait_irq(300, n);
    `CHK("fall_done", 1'b1, irq)
    wr(sac_pkg::ADDR_EDGE_MODE, 8'h02, 8'hFF);
    fire <= 1'b1;
    wait_irq(300, n);
    `CHK("both_done", 1'b1, irq)
    // a mode write mid-conversion sends it back to wait for a new edge
    fire <= 1'b0;
    repeat (30) @(posedge ref_clk_i);
    wr(sac_pkg::ADDR_MODE, 8'hCD, 8'hFF);
    wait_irq(300, n);
    `CHK("hw_abort", 1'b0, irq)
    final_report;
  end
endmodule
`default_nettype wire
